// >>> logic/mrb_pkg.sv
// shared constants and carrier types for the retry, back-off and pad-strip block
// assumes one 100 MHz core clock; nothing here holds state
package mrb_pkg;

    // ==========================================
    // clock and slot timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int SLOT_BITS = 512;
    localparam int BIT_TIME_100M_NS = 10;
    localparam int BIT_TIME_10M_NS = 100;
    localparam int SLOT_CYC_100M = (SLOT_BITS * BIT_TIME_100M_NS) / CLK_PERIOD_NS;
    localparam int SLOT_CYC_10M = (SLOT_BITS * BIT_TIME_10M_NS) / CLK_PERIOD_NS;
    localparam int SLOT_CNT_W = 16;

    // ==========================================
    // retry and back-off
    localparam logic [4:0] MAX_ATTEMPTS = 5'h10;
    localparam logic [4:0] K_CAP = 5'h0a;
    localparam int LFSR_W = 20;
    localparam logic [19:0] LFSR_SEED = 20'h0_0001;
    localparam int LFSR_TAP_A = 19;
    localparam int LFSR_TAP_B = 16;
    localparam logic [1:0] LIMSEL_10 = 2'h0;
    localparam logic [1:0] LIMSEL_8 = 2'h1;
    localparam logic [1:0] LIMSEL_4 = 2'h2;
    localparam logic [1:0] LIMSEL_1 = 2'h3;
    localparam logic [4:0] BITS_10 = 5'h0a;
    localparam logic [4:0] BITS_8 = 5'h08;
    localparam logic [4:0] BITS_4 = 5'h04;
    localparam logic [4:0] BITS_1 = 5'h01;
    localparam logic [9:0] BACKOFF_MIN = 10'h001;

    // ==========================================
    // receive framing
    localparam logic [10:0] LEN_HI_IDX = 11'h00c;
    localparam logic [10:0] LEN_LO_IDX = 11'h00d;
    localparam logic [10:0] HDR_BYTES = 11'h00e;
    localparam logic [15:0] MIN_DATA_LEN = 16'h002e;
    localparam logic [10:0] IDX_MAX = 11'h7ff;
    localparam int FIFO_DEPTH = 8;

    // ==========================================
    // carriers
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } mrb_byte_t;

    typedef struct packed {
        logic retry_error;
        logic [4:0] attempts;
    } mrb_tx_status_t;

    typedef enum logic {
        MRB_SPEED_10M,
        MRB_SPEED_100M
    } mrb_speed_t;

endpackage : mrb_pkg

// >>> logic/mrb_top.sv
// transmit retry control with truncated exponential back-off, and receive pad stripping
// assumes the line-side collision and attempt-done pins are asynchronous, the receive
// byte stream and the frame queue sit on core_clk
`timescale 1ns/1ns

// ==========================================
// small synchronous FIFO with valid/ready on both sides
module mrb_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // fill side
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    // drain side
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + (AW+1)'(1);
        end else if (pop && !push) begin
            count <= count - (AW+1)'(1);
        end
    end
endmodule : mrb_fifo

// ==========================================
// top level
module mrb_top #(
    parameter int SLOT_CYC_10M = mrb_pkg::SLOT_CYC_10M
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // control bits from host configuration
    input wire logic retry_disable_bit,
    input wire logic auto_pad_strip_bit,
    input wire logic [1:0] backoff_limit_field,
    input wire mrb_pkg::mrb_speed_t link_speed,
    // transmit frame queue
    input wire logic tx_frame_valid,
    output logic tx_frame_next,
    output mrb_pkg::mrb_tx_status_t tx_status,
    output logic tx_status_valid,
    // line side, asynchronous pins
    output logic tx_attempt,
    input wire logic line_collision,
    input wire logic line_tx_done,
    // receive byte stream in
    input wire mrb_pkg::mrb_byte_t rx_in,
    input wire logic rx_in_valid,
    output logic rx_in_ready,
    // receive byte stream out
    output mrb_pkg::mrb_byte_t rx_out,
    output logic rx_out_valid,
    input wire logic rx_out_ready
);

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ATTEMPT,
        ST_BACKOFF
    } mrb_tx_state_t;

    // ==========================================
    // pin synchronisers
    logic col_meta;
    logic col_sync;
    logic done_meta;
    logic done_sync;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            col_meta <= 1'b0;
            col_sync <= 1'b0;
            done_meta <= 1'b0;
            done_sync <= 1'b0;
        end else begin
            col_meta <= line_collision;
            col_sync <= col_meta;
            done_meta <= line_tx_done;
            done_sync <= done_meta;
        end
    end

    // ==========================================
    // random source, free running so each collision sees a fresh value
    logic [mrb_pkg::LFSR_W-1:0] lfsr;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lfsr <= mrb_pkg::LFSR_SEED;
        end else begin
            lfsr <= {lfsr[mrb_pkg::LFSR_W-2:0],
                     lfsr[mrb_pkg::LFSR_TAP_A] ^ lfsr[mrb_pkg::LFSR_TAP_B]};
        end
    end

    // ==========================================
    // transmit retry state machine
    mrb_tx_state_t state;
    logic [4:0] attempts;
    logic [9:0] backoff_cnt;
    logic [mrb_pkg::SLOT_CNT_W-1:0] slot_cnt;
    logic [mrb_pkg::SLOT_CNT_W-1:0] slot_len;
    logic slot_tick;
    logic [4:0] k_exp;
    logic [4:0] limit_bits;
    logic [4:0] use_bits;
    logic [9:0] draw_mask;
    logic [9:0] draw;
    logic give_up;

    // slot length follows the link bit rate
    assign slot_len = (link_speed == mrb_pkg::MRB_SPEED_100M) ?
        mrb_pkg::SLOT_CNT_W'(mrb_pkg::SLOT_CYC_100M) :
        mrb_pkg::SLOT_CNT_W'(SLOT_CYC_10M);
    assign slot_tick = (slot_cnt == slot_len - mrb_pkg::SLOT_CNT_W'(1));

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            slot_cnt <= '0;
        end else if (state != ST_BACKOFF || slot_tick) begin
            slot_cnt <= '0;
        end else begin
            slot_cnt <= slot_cnt + mrb_pkg::SLOT_CNT_W'(1);
        end
    end

    // retries so far equal attempts made, since this collision ends one attempt
    always_comb begin
        k_exp = (attempts > mrb_pkg::K_CAP) ? mrb_pkg::K_CAP : attempts;
        unique case (backoff_limit_field)
            mrb_pkg::LIMSEL_10: limit_bits = mrb_pkg::BITS_10;
            mrb_pkg::LIMSEL_8: limit_bits = mrb_pkg::BITS_8;
            mrb_pkg::LIMSEL_4: limit_bits = mrb_pkg::BITS_4;
            mrb_pkg::LIMSEL_1: limit_bits = mrb_pkg::BITS_1;
        endcase
        use_bits = (k_exp < limit_bits) ? k_exp : limit_bits;
        draw_mask = 10'((11'h001 << use_bits) - 11'h001);
        draw = lfsr[9:0] & draw_mask;
    end

    assign give_up = retry_disable_bit || (attempts == mrb_pkg::MAX_ATTEMPTS);

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
            attempts <= '0;
            backoff_cnt <= '0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (tx_frame_valid) begin
                        state <= ST_ATTEMPT;
                        attempts <= 5'h01;
                    end
                end
                ST_ATTEMPT: begin
                    if (col_sync) begin
                        if (give_up) begin
                            state <= ST_IDLE;
                        end else begin
                            state <= ST_BACKOFF;
                            // a zero draw still waits one slot so r stays above zero
                            backoff_cnt <= (draw == '0) ? mrb_pkg::BACKOFF_MIN : draw;
                        end
                    end else if (done_sync) begin
                        state <= ST_IDLE;
                    end
                end
                ST_BACKOFF: begin
                    if (slot_tick) begin
                        if (backoff_cnt == mrb_pkg::BACKOFF_MIN) begin
                            state <= ST_ATTEMPT;
                            attempts <= attempts + 5'h01;
                        end
                        backoff_cnt <= backoff_cnt - 10'h001;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    assign tx_attempt = (state == ST_ATTEMPT);

    // status and queue advance, one pulse per give_up collision or per done_sync in ST_ATTEMPT
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            tx_status <= '0;
            tx_status_valid <= 1'b0;
            tx_frame_next <= 1'b0;
        end else begin
            tx_status_valid <= 1'b0;
            tx_frame_next <= 1'b0;
            if (state == ST_ATTEMPT && col_sync && give_up) begin
                tx_status <= '{retry_error: 1'b1, attempts: attempts};
                tx_status_valid <= 1'b1;
                tx_frame_next <= 1'b1;
            end else if (state == ST_ATTEMPT && done_sync) begin
                tx_status <= '{retry_error: 1'b0, attempts: attempts};
                tx_status_valid <= 1'b1;
                tx_frame_next <= 1'b1;
            end
        end
    end

    // ==========================================
    // receive pad and FCS stripping
    logic [10:0] rx_idx;
    logic [7:0] len_hi;
    logic [15:0] len_field;
    logic strip_en;
    logic strip_now;
    logic [10:0] keep_end;
    logic keep;
    logic take;
    logic fifo_in_ready;
    mrb_pkg::mrb_byte_t fifo_in;
    logic [8:0] fifo_out;

    assign len_field = {len_hi, rx_in.data};
    // dropped bytes are swallowed without waiting on the FIFO
    assign rx_in_ready = keep ? fifo_in_ready : 1'b1;
    assign take = rx_in_valid && rx_in_ready;

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rx_idx <= '0;
            len_hi <= '0;
            strip_en <= 1'b0;
            strip_now <= 1'b0;
            keep_end <= '0;
        end else if (take) begin
            if (rx_in.last) begin
                rx_idx <= '0;
                strip_now <= 1'b0;
            end else if (rx_idx != mrb_pkg::IDX_MAX) begin
                rx_idx <= rx_idx + 11'h001;
            end
            // sample the enable at frame start so a frame is never half stripped
            if (rx_idx == '0) begin
                strip_en <= auto_pad_strip_bit;
            end
            if (rx_idx == mrb_pkg::LEN_HI_IDX) begin
                len_hi <= rx_in.data;
            end
            if (rx_idx == mrb_pkg::LEN_LO_IDX && !rx_in.last) begin
                strip_now <= strip_en && (len_field < mrb_pkg::MIN_DATA_LEN);
                keep_end <= mrb_pkg::HDR_BYTES + len_field[10:0];
            end
        end
    end

    // once stripping, only header and length-field data survive; pad and FCS go
    assign keep = !strip_now || (rx_idx < keep_end);

    always_comb begin
        fifo_in.data = rx_in.data;
        fifo_in.last = rx_in.last;
        if (strip_now && rx_idx == keep_end - 11'h001) begin
            fifo_in.last = 1'b1;
        end
        if (strip_en && rx_idx == mrb_pkg::LEN_LO_IDX &&
            len_field == '0) begin
            fifo_in.last = 1'b1;
        end
    end

    mrb_fifo #(
        .WIDTH($bits(mrb_pkg::mrb_byte_t)),
        .DEPTH(mrb_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .core_clk(core_clk),
        .rstn(rstn),
        .in_data(fifo_in),
        .in_valid(rx_in_valid && keep),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out),
        .out_valid(rx_out_valid),
        .out_ready(rx_out_ready)
    );

    assign rx_out = mrb_pkg::mrb_byte_t'(fifo_out);

endmodule : mrb_top

// >>> verif/mrb_phy_model.sv
// line-side model: answers every attempt with a collision or a clean finish
// assumes tx_attempt and tx_frame_next from the block, core_clk domain
`timescale 1ns/1ns
module mrb_phy_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // collisions wanted per frame, from the bench
    input wire logic [4:0] col_n,
    // block side
    input wire logic tx_attempt,
    input wire logic tx_frame_next,
    // line pins
    output logic line_collision,
    output logic line_tx_done
);
    localparam logic [3:0] LAT = 4'h3;
    logic [3:0] cnt;
    logic [4:0] nth;
    logic att_q;
    logic hit;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) cnt <= 4'h0;
        else if (!tx_attempt) cnt <= 4'h0;
        else if (!hit) cnt <= cnt + 4'h1;
    end
    // attempts answered in this frame, cleared when the queue advances
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            att_q <= 1'b0;
            nth <= 5'h00;
        end else begin
            att_q <= tx_attempt;
            if (tx_frame_next) nth <= 5'h00;
            else if (att_q && !tx_attempt) nth <= nth + 5'h01;
        end
    end
    // pins fall with tx_attempt so nothing stands into the next attempt
    assign hit = tx_attempt && cnt >= LAT;
    assign line_collision = hit && nth < col_n;
    assign line_tx_done = hit && nth >= col_n;
endmodule : mrb_phy_model

// >>> verif/mrb_top_sva.sv
// assertions on the ports of the retry, back-off and pad-strip block
// assumes control inputs stay steady while a frame is in flight
`timescale 1ns/1ns
module mrb_top_sva #(
    parameter int SLOT_CYC_10M = mrb_pkg::SLOT_CYC_10M
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // control
    input wire logic retry_disable_bit,
    input wire logic [1:0] backoff_limit_field,
    input wire mrb_pkg::mrb_speed_t link_speed,
    // transmit
    input wire logic tx_frame_next,
    input wire mrb_pkg::mrb_tx_status_t tx_status,
    input wire logic tx_status_valid,
    input wire logic tx_attempt,
    // receive out
    input wire mrb_pkg::mrb_byte_t rx_out,
    input wire logic rx_out_valid,
    input wire logic rx_out_ready
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rstn);
    // ==========================================
    // helpers: idle cycles before a retry, attempts made in the frame
    logic att_q, bo;
    logic [4:0] nat, lim, k;
    int unsigned low, slot;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            att_q <= 1'b0;
            low <= 0;
        end else begin
            att_q <= tx_attempt;
            low <= tx_attempt ? 0 : low + 1;
        end
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bo <= 1'b0;
            nat <= 5'h00;
        end else if (tx_status_valid) begin
            bo <= 1'b0;
            nat <= 5'h00;
        end else if (att_q && !tx_attempt) begin
            bo <= 1'b1;
            nat <= nat + 5'h01;
        end
    end
    always_comb begin
        case (backoff_limit_field)
            mrb_pkg::LIMSEL_8: lim = mrb_pkg::BITS_8;
            mrb_pkg::LIMSEL_4: lim = mrb_pkg::BITS_4;
            mrb_pkg::LIMSEL_1: lim = mrb_pkg::BITS_1;
            default: lim = mrb_pkg::BITS_10;
        endcase
    end
    assign k = (nat < lim) ? nat : lim;
    assign slot = (link_speed == mrb_pkg::MRB_SPEED_100M) ? mrb_pkg::SLOT_CYC_100M : SLOT_CYC_10M;
    // ==========================================
    // properties
    property p_pair; tx_status_valid |-> tx_frame_next ##1 !tx_status_valid; endproperty
    a_pair: assert property (p_pair) else $error("status pulse bad");
    property p_once; retry_disable_bit && $fell(tx_attempt) |-> tx_status_valid && tx_status.attempts == 5'h01; endproperty
    a_once: assert property (p_once) else $error("retried with retries off");
    property p_range; tx_status_valid |-> tx_status.attempts inside {[5'h01:5'h10]}; endproperty
    a_range: assert property (p_range) else $error("attempt count out of range");
    property p_err16; tx_status_valid && tx_status.retry_error && !retry_disable_bit |-> tx_status.attempts == 5'h10; endproperty
    a_err16: assert property (p_err16) else $error("retry error too early");
    property p_nat; tx_status_valid |-> tx_status.attempts == nat + 5'h01; endproperty
    a_nat: assert property (p_nat) else $error("attempt count differs from line");
    property p_bo_min; $rose(tx_attempt) && bo |-> low >= slot; endproperty
    a_bo_min: assert property (p_bo_min) else $error("back-off under one slot");
    property p_bo_max; $rose(tx_attempt) && bo |-> low < (slot << k); endproperty
    a_bo_max: assert property (p_bo_max) else $error("back-off too long");
    property p_hold; rx_out_valid && !rx_out_ready |=> rx_out_valid && $stable(rx_out); endproperty
    a_hold: assert property (p_hold) else $error("rx byte lost while stalled");
    c_err16: cover property (tx_status_valid && tx_status.attempts == 5'h10);
    c_once: cover property (tx_status_valid && retry_disable_bit && tx_status.retry_error);
    c_stall: cover property (rx_out_valid && !rx_out_ready);
endmodule : mrb_top_sva

bind mrb_top mrb_top_sva #(.SLOT_CYC_10M(SLOT_CYC_10M)) u_sva (.core_clk, .rstn, .retry_disable_bit,
    .backoff_limit_field, .link_speed, .tx_frame_next, .tx_status, .tx_status_valid, .tx_attempt,
    .rx_out, .rx_out_valid, .rx_out_ready);

// >>> verif/mrb_top_tb.sv
// self-checking bench: transmit retries against a line model, receive pad stripping
// assumes the 10M slot shortened to 64 cycles so back-off waits stay short
`timescale 1ns/1ns
module mrb_top_tb;
    logic core_clk, rstn, retry_disable_bit, auto_pad_strip_bit, tx_frame_valid, tx_frame_next;
    logic tx_status_valid, tx_attempt, line_collision, line_tx_done, rx_in_valid, rx_in_ready;
    logic rx_out_valid, rx_out_ready, refused;
    logic [1:0] backoff_limit_field;
    logic [4:0] col_n;
    logic [8:0] exp_q[$];
    mrb_pkg::mrb_speed_t link_speed;
    mrb_pkg::mrb_tx_status_t tx_status;
    mrb_pkg::mrb_byte_t rx_in, rx_out;
    int miscompares = 0;
    int samples_checked = 0;

    mrb_top #(.SLOT_CYC_10M(64)) DUT (.core_clk, .rstn, .retry_disable_bit, .auto_pad_strip_bit,
        .backoff_limit_field, .link_speed, .tx_frame_valid, .tx_frame_next, .tx_status, .tx_status_valid,
        .tx_attempt, .line_collision, .line_tx_done, .rx_in, .rx_in_valid, .rx_in_ready, .rx_out,
        .rx_out_valid, .rx_out_ready);
    mrb_phy_model u_phy (.core_clk, .rstn, .col_n, .tx_attempt, .tx_frame_next, .line_collision,
        .line_tx_done);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude

    task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic bound(input int w, input int lim);
        if (w >= lim) begin
            miscompares++;
            $display("wrong value at %0t: wait ran out", $time);
            conclude();
        end
    endtask : bound

    function automatic logic [5:0] tx_exp(input logic dis, input logic [4:0] ncol);
        if (dis) return (ncol != 5'h00) ? 6'h21 : 6'h01;
        if (ncol >= 5'h10) return 6'h30;
        return {1'b0, ncol + 5'h01};
    endfunction : tx_exp

    task automatic send(input logic dis, input logic [4:0] ncol);
        int w;
        retry_disable_bit = dis;
        col_n = ncol;
        tx_frame_valid = 1'b1;
        w = 0;
        while (tx_frame_next !== 1'b1 && w < 9999) begin
            tick(1);
            w++;
        end
        bound(w, 9999);
        tx_frame_valid = 1'b0;
        check({2'h0, tx_status_valid, tx_status}, {2'h0, 1'b1, tx_exp(dis, ncol)}, "tx status");
        tick(1);
    endtask : send

    task automatic rx_frame(input logic strip, input int len);
        int total, keep, w;
        logic ok;
        total = 18 + ((len < 46) ? 46 : len);
        keep = (strip && len < 46) ? 14 + len : total;
        auto_pad_strip_bit = strip;
        for (int i = 0; i < total; i++) begin
            rx_in.data = (i == 12) ? 8'(len >> 8) : (i == 13) ? 8'(len) : 8'($urandom);
            rx_in.last = (i == total - 1);
            rx_in_valid = 1'b1;
            w = 0;
            do begin
                #4;
                ok = rx_in_ready;
                if (ok !== 1'b1) refused = 1'b1;
                tick(1);
                w++;
            end while (ok !== 1'b1 && w < 999);
            bound(w, 999);
            if (i < keep) exp_q.push_back({rx_in.data, i == keep - 1});
        end
        rx_in_valid = 1'b0;
        tick(1);
    endtask : rx_frame

    // ==========================================
    // receive sink: holds off until the fifo has refused once, then stalls at random
    always @(posedge core_clk) begin
        if (rstn === 1'b1 && rx_out_valid === 1'b1 && rx_out_ready === 1'b1) begin
            if (exp_q.size() == 0) begin
                samples_checked++;
                miscompares++;
                $display("wrong value at %0t: extra rx byte %h", $time, rx_out);
            end else check(rx_out, exp_q.pop_front(), "rx byte");
        end
        #1;
        rx_out_ready = refused && ($urandom % 4 != 0);
    end

    initial begin
        int w;
        void'($urandom(99262));
        rstn = 1'b0;
        retry_disable_bit = 1'b0;
        auto_pad_strip_bit = 1'b0;
        backoff_limit_field = 2'h3;
        link_speed = mrb_pkg::MRB_SPEED_10M;
        tx_frame_valid = 1'b0;
        col_n = 5'h00;
        rx_in = '0;
        rx_in_valid = 1'b0;
        rx_out_ready = 1'b0;
        refused = 1'b0;
        tick(5);
        rstn = 1'b1;
        tick(1);
        send(1'b1, 5'h1f);
        send(1'b1, 5'h00);
        send(1'b0, 5'h1f);
        send(1'b0, 5'h0f);
        link_speed = mrb_pkg::MRB_SPEED_100M;
        send(1'b0, 5'h02);
        link_speed = mrb_pkg::MRB_SPEED_10M;
        for (int i = 0; i < 12; i++) begin
            backoff_limit_field = 2'(i);
            send(1'($urandom % 2), 5'($urandom % 6));
        end
        $display("test transmit done");
        rx_frame(1'b1, 46);
        check({8'h00, refused}, 9'h001, "fifo refused");
        rx_frame(1'b1, 45);
        rx_frame(1'b1, 0);
        rx_frame(1'b0, 10);
        for (int i = 0; i < 8; i++) begin
            rx_frame(1'($urandom % 2), $urandom % 80);
        end
        w = 0;
        while (exp_q.size() != 0 && w < 999) begin
            tick(1);
            w++;
        end
        bound(w, 999);
        tick(2);
        check({8'h00, rx_out_valid}, 9'h000, "fifo drained");
        $display("test receive done");
        conclude();
    end
endmodule : mrb_top_tb
